// file: logic/ddp_cfg.svh
// constants for the dual converter data input path
`ifndef DDP_CFG_SVH
`define DDP_CFG_SVH
`define DDP_OFS_MEM_CFG     12'h000
`define DDP_OFS_REF_CUR     12'h1c0
`define DDP_OFS_CLK_DLY     12'h1c1
`define DDP_OFS_POWER       12'h1c3
`define DDP_OFS_MISC        12'h1c4
`define DDP_IDX_SCALE       4
`define DDP_BIT_DIRECT      4
`define DDP_BIT_ILV         5
`define DDP_BIT_ILV_CORE    6
`define DDP_BIT_TERM        7
`define DDP_BIT_PDN_A       12
`define DDP_BIT_PDN_B       11
`define DDP_RST_MEM_CFG     8'h00
`define DDP_RST_REF_CUR     2'h0
`define DDP_RST_CLK_DLY     12'h000
`define DDP_RST_POWER       13'h1fc0
`define DDP_RST_MISC        8'h80
`define DDP_LATENCY_EDGES   18
`define DDP_DLY_STEP_PS     100
`define DDP_TRIM_RANGE_PS   3000
`endif

// file: logic/ddp_pkg.sv
// types for the dual converter data input path
`default_nettype none
package ddp_pkg;
    typedef logic [13:0] ddp_sample_t;
    typedef logic [3:0]  ddp_delay_t;
    typedef enum logic [1:0] {
        DDP_SRC_DIRECT,
        DDP_SRC_MEMORY,
        DDP_SRC_INTERLEAVE
    } ddp_src_t;
endpackage
`default_nettype wire

// file: logic/ddp_sync.sv
// two-flop level synchroniser
`default_nettype none
module ddp_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;
    logic [W-1:0] nxt_meta;
    logic [W-1:0] nxt_q;

    always_comb begin
        nxt_meta = d;
        nxt_q    = meta_ff;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= '0;
            q_ff    <= '0;
        end else begin
            meta_ff <= nxt_meta;
            q_ff    <= nxt_q;
        end
    end

    assign q = q_ff;
endmodule
`default_nettype wire

// file: logic/ddp_pipe.sv
// fixed-length pipeline of sample pairs on the link clock
`default_nettype none
`include "ddp_cfg.svh"
module ddp_pipe (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire ddp_pkg::ddp_sample_t in_even,
    input  wire ddp_pkg::ddp_sample_t in_odd,
    output ddp_pkg::ddp_sample_t      out_even,
    output ddp_pkg::ddp_sample_t      out_odd
);
    // two edges per link cycle; the output register takes one cycle
    localparam int STAGES = (`DDP_LATENCY_EDGES / 2) - 1;
    ddp_pkg::ddp_sample_t even_ff [STAGES];
    ddp_pkg::ddp_sample_t odd_ff  [STAGES];
    ddp_pkg::ddp_sample_t nxt_even [STAGES];
    ddp_pkg::ddp_sample_t nxt_odd  [STAGES];

    always_comb begin
        nxt_even[0] = in_even;
        nxt_odd[0]  = in_odd;
        for (int i = 1; i < STAGES; i++) begin
            nxt_even[i] = even_ff[i-1];
            nxt_odd[i]  = odd_ff[i-1];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < STAGES; i++) begin
                even_ff[i] <= '0;
                odd_ff[i]  <= '0;
            end
        end else begin
            for (int i = 0; i < STAGES; i++) begin
                even_ff[i] <= nxt_even[i];
                odd_ff[i]  <= nxt_odd[i];
            end
        end
    end

    assign out_even = even_ff[STAGES-1];
    assign out_odd  = odd_ff[STAGES-1];
endmodule
`default_nettype wire

// file: logic/ddp_top.sv
// dual converter data input path with apb registers
`default_nettype none
`include "ddp_cfg.svh"
module ddp_top (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 link_clk,
    input  wire ddp_pkg::ddp_sample_t port_a_data,
    input  wire ddp_pkg::ddp_sample_t port_b_data,
    input  wire ddp_pkg::ddp_sample_t mem_a_data,
    input  wire ddp_pkg::ddp_sample_t mem_b_data,
    output ddp_pkg::ddp_sample_t      core_a_even,
    output ddp_pkg::ddp_sample_t      core_a_odd,
    output ddp_pkg::ddp_sample_t      core_b_even,
    output ddp_pkg::ddp_sample_t      core_b_odd,
    output logic                      core_a_pdn,
    output logic                      core_b_pdn,
    output logic                      lvds_term_en,
    output logic      [1:0]           ref_cur_sel,
    output ddp_pkg::ddp_delay_t       out_clock_one_delay,
    output ddp_pkg::ddp_delay_t       out_clock_two_delay,
    output ddp_pkg::ddp_delay_t       loop_clock_delay
);
    // byte address of a printed register index
    function automatic logic [11:0] ddp_byte_addr(input logic [11:0] idx);
        ddp_byte_addr = 12'(idx * `DDP_IDX_SCALE);
    endfunction

    // register file
    logic [7:0]  mem_cfg_ff;
    logic [1:0]  ref_cur_ff;
    logic [11:0] clk_dly_ff;
    logic [12:0] power_ff;
    logic [7:0]  misc_ff;
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    logic [7:0]  nxt_mem_cfg;
    logic [1:0]  nxt_ref_cur;
    logic [11:0] nxt_clk_dly;
    logic [12:0] nxt_power;
    logic [7:0]  nxt_misc;
    logic [31:0] nxt_prdata;
    logic        nxt_pready;
    logic        nxt_pslverr;
    logic        access;
    logic        hit;
    logic [31:0] rd_word;

    always_comb begin
        access      = psel && penable && !pready_ff;
        nxt_mem_cfg = mem_cfg_ff;
        nxt_ref_cur = ref_cur_ff;
        nxt_clk_dly = clk_dly_ff;
        nxt_power   = power_ff;
        nxt_misc    = misc_ff;
        hit         = 1'b1;
        rd_word     = 32'h0000_0000;
        unique case (paddr)
            ddp_byte_addr(`DDP_OFS_MEM_CFG): rd_word = {24'h00_0000, mem_cfg_ff};
            ddp_byte_addr(`DDP_OFS_REF_CUR): rd_word = {30'h0000_0000, ref_cur_ff};
            ddp_byte_addr(`DDP_OFS_CLK_DLY): rd_word = {20'h0_0000, clk_dly_ff};
            ddp_byte_addr(`DDP_OFS_POWER):   rd_word = {19'h0_0000, power_ff};
            ddp_byte_addr(`DDP_OFS_MISC):    rd_word = {24'h00_0000, misc_ff};
            default:                         hit = 1'b0;
        endcase
        if (access && pwrite && hit) begin
            unique case (paddr)
                ddp_byte_addr(`DDP_OFS_MEM_CFG): nxt_mem_cfg = pwdata[7:0];
                ddp_byte_addr(`DDP_OFS_REF_CUR): nxt_ref_cur = pwdata[1:0];
                ddp_byte_addr(`DDP_OFS_CLK_DLY): nxt_clk_dly = pwdata[11:0];
                ddp_byte_addr(`DDP_OFS_POWER):   nxt_power = pwdata[12:0];
                ddp_byte_addr(`DDP_OFS_MISC):    nxt_misc = pwdata[7:0];
                default:                         nxt_misc = misc_ff;
            endcase
        end
        nxt_pready  = access;
        nxt_pslverr = access && !hit;
        nxt_prdata  = (access && !pwrite) ? rd_word : 32'h0000_0000;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_cfg_ff <= `DDP_RST_MEM_CFG;
            ref_cur_ff <= `DDP_RST_REF_CUR;
            clk_dly_ff <= `DDP_RST_CLK_DLY;
            power_ff   <= `DDP_RST_POWER;
            misc_ff    <= `DDP_RST_MISC;
            prdata_ff  <= 32'h0000_0000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            mem_cfg_ff <= nxt_mem_cfg;
            ref_cur_ff <= nxt_ref_cur;
            clk_dly_ff <= nxt_clk_dly;
            power_ff   <= nxt_power;
            misc_ff    <= nxt_misc;
            prdata_ff  <= nxt_prdata;
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    // static controls registered one pclk cycle after the bus-domain registers
    logic                term_ff;
    logic [1:0]          ref_sel_ff;
    ddp_pkg::ddp_delay_t dly_one_ff;
    ddp_pkg::ddp_delay_t dly_two_ff;
    ddp_pkg::ddp_delay_t dly_loop_ff;
    logic                pdn_a_ff;
    logic                pdn_b_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            term_ff     <= 1'b1;
            ref_sel_ff  <= `DDP_RST_REF_CUR;
            dly_one_ff  <= 4'h0;
            dly_two_ff  <= 4'h0;
            dly_loop_ff <= 4'h0;
            pdn_a_ff    <= 1'b1;
            pdn_b_ff    <= 1'b1;
        end else begin
            term_ff     <= misc_ff[`DDP_BIT_TERM];
            ref_sel_ff  <= ref_cur_ff;
            dly_one_ff  <= clk_dly_ff[7:4];
            dly_two_ff  <= clk_dly_ff[3:0];
            dly_loop_ff <= clk_dly_ff[11:8];
            pdn_a_ff    <= power_ff[`DDP_BIT_PDN_A];
            pdn_b_ff    <= power_ff[`DDP_BIT_PDN_B];
        end
    end

    // crossing of routing and power-down controls into the link domain
    logic [4:0] ctl_link;
    logic       lrst_n_meta_ff;
    logic       lrst_n_ff;

    always_ff @(posedge link_clk or negedge presetn) begin
        if (!presetn) begin
            lrst_n_meta_ff <= 1'b0;
            lrst_n_ff      <= 1'b0;
        end else begin
            lrst_n_meta_ff <= 1'b1;
            lrst_n_ff      <= lrst_n_meta_ff;
        end
    end

    ddp_sync #(
        .W(5)
    ) u_sync (
        .clk   (link_clk),
        .rst_n (lrst_n_ff),
        .d     ({mem_cfg_ff[`DDP_BIT_DIRECT], mem_cfg_ff[`DDP_BIT_ILV], mem_cfg_ff[`DDP_BIT_ILV_CORE],
                 power_ff[`DDP_BIT_PDN_A], power_ff[`DDP_BIT_PDN_B]}),
        .q     (ctl_link)
    );

    // capture: even half on falling edge, odd half on rising edge
    ddp_pkg::ddp_sample_t a_even_ff;
    ddp_pkg::ddp_sample_t b_even_ff;
    ddp_pkg::ddp_sample_t a_odd_ff;
    ddp_pkg::ddp_sample_t b_odd_ff;
    ddp_pkg::ddp_sample_t a_even_rt_ff;
    ddp_pkg::ddp_sample_t b_even_rt_ff;

    always_ff @(negedge link_clk or negedge lrst_n_ff) begin
        if (!lrst_n_ff) begin
            a_even_ff <= '0;
            b_even_ff <= '0;
        end else begin
            a_even_ff <= port_a_data;
            b_even_ff <= port_b_data;
        end
    end

    // select source and routing
    ddp_pkg::ddp_src_t    src;
    ddp_pkg::ddp_sample_t sel_a_even;
    ddp_pkg::ddp_sample_t sel_a_odd;
    ddp_pkg::ddp_sample_t sel_b_even;
    ddp_pkg::ddp_sample_t sel_b_odd;

    always_comb begin
        if (!ctl_link[4]) begin
            src = ddp_pkg::DDP_SRC_DIRECT;
        end else if (ctl_link[3]) begin
            src = ddp_pkg::DDP_SRC_INTERLEAVE;
        end else begin
            src = ddp_pkg::DDP_SRC_MEMORY;
        end
        sel_a_even = a_even_rt_ff;
        sel_a_odd  = a_odd_ff;
        sel_b_even = b_even_rt_ff;
        sel_b_odd  = b_odd_ff;
        unique case (src)
            ddp_pkg::DDP_SRC_DIRECT: begin
                sel_a_even = a_even_rt_ff;
                sel_a_odd  = a_odd_ff;
                sel_b_even = b_even_rt_ff;
                sel_b_odd  = b_odd_ff;
            end
            ddp_pkg::DDP_SRC_MEMORY: begin
                sel_a_even = mem_a_data;
                sel_a_odd  = mem_a_data;
                sel_b_even = mem_b_data;
                sel_b_odd  = mem_b_data;
            end
            ddp_pkg::DDP_SRC_INTERLEAVE: begin
                sel_a_even = a_even_rt_ff;
                sel_a_odd  = b_odd_ff;
                sel_b_even = a_even_rt_ff;
                sel_b_odd  = b_odd_ff;
            end
        endcase
        if (src == ddp_pkg::DDP_SRC_INTERLEAVE && !ctl_link[2]) begin
            sel_b_even = b_even_rt_ff;
            sel_b_odd  = b_odd_ff;
        end
    end

    always_ff @(posedge link_clk or negedge lrst_n_ff) begin
        if (!lrst_n_ff) begin
            a_odd_ff     <= '0;
            b_odd_ff     <= '0;
            a_even_rt_ff <= '0;
            b_even_rt_ff <= '0;
        end else begin
            a_odd_ff     <= port_a_data;
            b_odd_ff     <= port_b_data;
            a_even_rt_ff <= a_even_ff;
            b_even_rt_ff <= b_even_ff;
        end
    end

    // gate powered-down cores to zero before the pipeline
    ddp_pkg::ddp_sample_t pipe_a_even;
    ddp_pkg::ddp_sample_t pipe_a_odd;
    ddp_pkg::ddp_sample_t pipe_b_even;
    ddp_pkg::ddp_sample_t pipe_b_odd;

    ddp_pipe u_pipe_a (
        .clk      (link_clk),
        .rst_n    (lrst_n_ff),
        .in_even  (ctl_link[1] ? 14'h0000 : sel_a_even),
        .in_odd   (ctl_link[1] ? 14'h0000 : sel_a_odd),
        .out_even (pipe_a_even),
        .out_odd  (pipe_a_odd)
    );

    ddp_pipe u_pipe_b (
        .clk      (link_clk),
        .rst_n    (lrst_n_ff),
        .in_even  (ctl_link[0] ? 14'h0000 : sel_b_even),
        .in_odd   (ctl_link[0] ? 14'h0000 : sel_b_odd),
        .out_even (pipe_b_even),
        .out_odd  (pipe_b_odd)
    );

    ddp_pkg::ddp_sample_t out_a_even_ff;
    ddp_pkg::ddp_sample_t out_a_odd_ff;
    ddp_pkg::ddp_sample_t out_b_even_ff;
    ddp_pkg::ddp_sample_t out_b_odd_ff;

    always_ff @(posedge link_clk or negedge lrst_n_ff) begin
        if (!lrst_n_ff) begin
            out_a_even_ff <= '0;
            out_a_odd_ff  <= '0;
            out_b_even_ff <= '0;
            out_b_odd_ff  <= '0;
        end else begin
            out_a_even_ff <= pipe_a_even;
            out_a_odd_ff  <= pipe_a_odd;
            out_b_even_ff <= pipe_b_even;
            out_b_odd_ff  <= pipe_b_odd;
        end
    end

    assign prdata              = prdata_ff;
    assign pready              = pready_ff;
    assign pslverr             = pslverr_ff;
    assign core_a_even         = out_a_even_ff;
    assign core_a_odd          = out_a_odd_ff;
    assign core_b_even         = out_b_even_ff;
    assign core_b_odd          = out_b_odd_ff;
    assign core_a_pdn          = pdn_a_ff;
    assign core_b_pdn          = pdn_b_ff;
    assign lvds_term_en        = term_ff;
    assign ref_cur_sel         = ref_sel_ff;
    assign out_clock_one_delay = dly_one_ff;
    assign out_clock_two_delay = dly_two_ff;
    assign loop_clock_delay    = dly_loop_ff;
endmodule
`default_nettype wire

// file: tb/ddp_top_monitor.sv
// concurrent checks on the data path top ports
`default_nettype none
module ddp_top_monitor (
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [11:0]          paddr,
    input wire logic [31:0]          pwdata,
    input wire logic [31:0]          prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    input wire logic                 link_clk,
    input wire ddp_pkg::ddp_sample_t core_a_even,
    input wire ddp_pkg::ddp_sample_t core_a_odd,
    input wire logic                 core_a_pdn,
    input wire logic                 core_b_pdn,
    input wire logic                 lvds_term_en,
    input wire logic [1:0]           ref_cur_sel,
    input wire ddp_pkg::ddp_delay_t  out_clock_one_delay,
    input wire ddp_pkg::ddp_delay_t  out_clock_two_delay,
    input wire ddp_pkg::ddp_delay_t  loop_clock_delay
);
    wire wr = psel && penable && pready && pwrite;
    a_term_follow: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == 12'h710 |=> ##[0:1] lvds_term_en == $past(pwdata[7])) else $error("term enable mismatch");
    a_pdn_a_follow: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == 12'h70c |=> ##[0:1] core_a_pdn == $past(pwdata[12])) else $error("core a pdn mismatch");
    a_pdn_b_follow: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == 12'h70c |=> ##[0:1] core_b_pdn == $past(pwdata[11])) else $error("core b pdn mismatch");
    a_out_dly: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == 12'h704 |=> ##[0:1] {out_clock_one_delay, out_clock_two_delay} == $past(pwdata[7:0]))
        else $error("output delay mismatch");
    a_loop_dly: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == 12'h704 |=> ##[0:1] loop_clock_delay == $past(pwdata[11:8])) else $error("loop delay mismatch");
    a_ref_read: assert property (@(posedge pclk) disable iff (!presetn)
        pready && !pwrite && paddr == 12'h700 |-> prdata == {30'h0, ref_cur_sel}) else $error("ref readback mismatch");
    // link cycles spent powered down, saturating past the pipeline flush time
    logic [4:0] quiet_cnt_ff;
    always_ff @(posedge link_clk or negedge presetn) begin
        if (!presetn) begin
            quiet_cnt_ff <= 5'h00;
        end else if (!core_a_pdn) begin
            quiet_cnt_ff <= 5'h00;
        end else if (quiet_cnt_ff != 5'h14) begin
            quiet_cnt_ff <= quiet_cnt_ff + 5'h01;
        end
    end
    a_quiet_core_a: assert property (@(posedge link_clk) disable iff (!presetn)
        quiet_cnt_ff == 5'h14 |-> core_a_even == 14'h0 && core_a_odd == 14'h0) else $error("core a not quiet");
    a_pready_wait: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable |-> !pready ##1 !pready ##1 pready) else $error("pready timing wrong");
    a_err_hole: assert property (@(posedge pclk) disable iff (!presetn)
        pready && paddr == 12'h7fc |-> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
    c_misc_wr: cover property (@(posedge pclk) wr && paddr == 12'h710);
    c_pdn_off: cover property (@(posedge pclk) $fell(core_a_pdn));
    c_refused: cover property (@(posedge pclk) pready && pslverr);
endmodule
`default_nettype wire

// file: tb/ddp_gen_model.sv
// behavioural data generator driving both lvds ports
`default_nettype none
module ddp_gen_model (
    input  wire logic                 link_clk,
    input  wire logic                 active,
    input  wire ddp_pkg::ddp_sample_t a_even,
    input  wire ddp_pkg::ddp_sample_t a_odd,
    input  wire ddp_pkg::ddp_sample_t b_even,
    input  wire ddp_pkg::ddp_sample_t b_odd,
    output ddp_pkg::ddp_sample_t      port_a_data,
    output ddp_pkg::ddp_sample_t      port_b_data
);
    initial begin
        port_a_data = 14'h0;
        port_b_data = 14'h0;
    end
    // even word held over the falling edge, idle lines toggle
    always @(posedge link_clk) begin
        port_a_data <= active ? a_even : ~port_a_data;
        port_b_data <= active ? b_even : ~port_b_data;
    end
    // odd word held over the rising edge
    always @(negedge link_clk) begin
        port_a_data <= active ? a_odd : ~port_a_data;
        port_b_data <= active ? b_odd : ~port_b_data;
    end
endmodule
`default_nettype wire

// file: tb/tb.sv
// testbench for the dual converter data input path
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; $display("unexpected %s exp=%h got=%h", nm, e, g); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 pclk, link_clk, presetn, psel, penable, pwrite, pready, pslverr, gen_on, err;
    logic                 core_a_pdn, core_b_pdn, lvds_term_en;
    logic [11:0]          paddr;
    logic [31:0]          pwdata, prdata, rd;
    logic [1:0]           ref_cur_sel;
    ddp_pkg::ddp_sample_t port_a_data, port_b_data, mem_a_data, mem_b_data, a_ev, a_od, b_ev, b_od;
    ddp_pkg::ddp_sample_t core_a_even, core_a_odd, core_b_even, core_b_odd;
    ddp_pkg::ddp_delay_t  out_clock_one_delay, out_clock_two_delay, loop_clock_delay;
    int                   err_total, n_checks;
    ddp_top ddp_top_i (.*);
    ddp_gen_model gen_i (.link_clk, .active(gen_on), .a_even(a_ev), .a_odd(a_od), .b_even(b_ev), .b_odd(b_od),
        .port_a_data, .port_b_data);
    initial begin
        pclk = 0;
        forever #50 pclk = ~pclk;
    end
    initial begin
        link_clk = 0;
        #7;
        forever #15 link_clk = ~link_clk;
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            err_total++;
            complete_run();
        end
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic lwait(input int n);
        repeat (n) @(posedge link_clk);
        @(negedge link_clk);
    endtask
    task automatic pwait();
        repeat (3) @(posedge pclk);
        @(negedge pclk);
    endtask
    task automatic chk_cores(input ddp_pkg::ddp_sample_t ae, ao, be, bo);
        `CHK("core a even", ae, core_a_even)
        `CHK("core a odd", ao, core_a_odd)
        `CHK("core b even", be, core_b_even)
        `CHK("core b odd", bo, core_b_odd)
    endtask
    task automatic t_reset();
        `CHK("term", 1'b1, lvds_term_en)
        `CHK("pdn", 2'b11, {core_a_pdn, core_b_pdn})
        `CHK("ref out", 2'h0, ref_cur_sel)
        apb(1'b0, 12'h000, 32'h0);
        `CHK("mem cfg", 32'h0000_0000, rd)
        apb(1'b0, 12'h70c, 32'h0);
        `CHK("power", 32'h0000_1fc0, rd)
        apb(1'b0, 12'h710, 32'h0);
        `CHK("misc", 32'h0000_0080, rd)
        apb(1'b0, 12'h704, 32'h0);
        `CHK("delays", 32'h0000_0000, rd)
    endtask
    task automatic t_regs();
        apb(1'b1, 12'h704, 32'h0000_07a5);
        pwait();
        `CHK("dly one", 4'ha, out_clock_one_delay)
        `CHK("dly two", 4'h5, out_clock_two_delay)
        `CHK("dly loop", 4'h7, loop_clock_delay)
        apb(1'b1, 12'h7fc, 32'hffff_ffff);
        `CHK("hole wr err", 1'b1, err)
        apb(1'b0, 12'h7fc, 32'h0);
        `CHK("hole rd", 33'h1_0000_0000, {err, rd})
        apb(1'b1, 12'h710, 32'h0000_0000);
        pwait();
        `CHK("term off", 1'b0, lvds_term_en)
        apb(1'b1, 12'h710, 32'h0000_0080);
        for (int i = 3; i >= 0; i--) begin
            apb(1'b1, 12'h700, 32'(i));
            apb(1'b0, 12'h700, 32'h0);
            `CHK("ref rd", 32'(i), rd)
            `CHK("ref out", 2'(i), ref_cur_sel)
        end
    endtask
    task automatic t_direct();
        apb(1'b1, 12'h70c, 32'h0000_0180);
        @(posedge pclk);
        a_ev   <= 14'h2001;
        a_od   <= 14'h1ffe;
        b_ev   <= 14'h3c0f;
        b_od   <= 14'h0aa5;
        gen_on <= 1'b1;
        lwait(30);
        chk_cores(14'h2001, 14'h1ffe, 14'h3c0f, 14'h0aa5);
        @(negedge link_clk);
        a_ev <= 14'h0c30;
        a_od <= 14'h3003;
        lwait(10);
        `CHK("latency hold", {14'h2001, 14'h1ffe}, {core_a_even, core_a_odd})
        lwait(1);
        `CHK("latency edge", {14'h0c30, 14'h3003}, {core_a_even, core_a_odd})
        lwait(20);
        chk_cores(14'h0c30, 14'h3003, 14'h3c0f, 14'h0aa5);
    endtask
    task automatic t_memory();
        apb(1'b1, 12'h000, 32'h0000_0010);
        lwait(30);
        chk_cores(14'h1234, 14'h1234, 14'h0321, 14'h0321);
        apb(1'b1, 12'h000, 32'h0000_0030);
        lwait(30);
        chk_cores(14'h0c30, 14'h0aa5, 14'h3c0f, 14'h0aa5);
        apb(1'b1, 12'h000, 32'h0000_0070);
        lwait(30);
        chk_cores(14'h0c30, 14'h0aa5, 14'h0c30, 14'h0aa5);
        apb(1'b1, 12'h000, 32'h0000_0000);
        lwait(30);
        chk_cores(14'h0c30, 14'h3003, 14'h3c0f, 14'h0aa5);
    endtask
    task automatic t_pdn();
        apb(1'b1, 12'h70c, 32'h0000_1580);
        apb(1'b1, 12'h700, 32'h0000_0001);
        lwait(30);
        chk_cores(14'h0, 14'h0, 14'h3c0f, 14'h0aa5);
        apb(1'b1, 12'h70c, 32'h0000_0b80);
        apb(1'b1, 12'h700, 32'h0000_0002);
        lwait(30);
        chk_cores(14'h0c30, 14'h3003, 14'h0, 14'h0);
    endtask
    initial begin
        presetn    = 1'b0;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = 12'h0;
        pwdata     = 32'h0;
        gen_on     = 1'b0;
        {a_ev, a_od, b_ev, b_od} = 56'h0;
        mem_a_data = 14'h1234;
        mem_b_data = 14'h0321;
        err_total  = 0;
        n_checks   = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        t_reset();
        t_regs();
        t_direct();
        t_memory();
        t_pdn();
        complete_run();
    end
endmodule
bind ddp_top ddp_top_monitor ddp_top_monitor_i (.*);
`default_nettype wire
